// >>> tw_defs.svh
`ifndef TW_DEFS_SVH
`define TW_DEFS_SVH

// Register byte addresses.
`define TW_CMD_ADR 4'h0
`define TW_STAT_ADR 4'h4
`define TW_DATA_ADR 4'h8

// Field positions inside the command and status registers.
`define TW_FLAG_BIT 7
`define TW_PRE_MSB 1

// Reset values.
`define TW_CMD_RST 8'h00
`define TW_DATA_RST 8'hFF
`define TW_PRE_RST 2'h0

// Status codes, prescaler bits taken as zero.
`define TW_SC_IDLE 8'hF8
`define TW_SC_START 8'h08
`define TW_SC_RSTART 8'h10
`define TW_SC_AW_ACK 8'h18
`define TW_SC_AW_NACK 8'h20
`define TW_SC_DW_ACK 8'h28
`define TW_SC_DW_NACK 8'h30
`define TW_SC_ARB 8'h38
`define TW_SC_AR_ACK 8'h40
`define TW_SC_AR_NACK 8'h48
`define TW_SC_DR_ACK 8'h50
`define TW_SC_DR_NACK 8'h58

// Timing: system clock period and serial bit period in ns.
`define TW_CLK_NS 20
`define TW_BIT_NS 10000
`define TW_QTR_CYC (`TW_BIT_NS / (4 * `TW_CLK_NS))

`endif

// >>> tw_pkg.sv
package tw_pkg;

    typedef struct packed {
        logic flag;
        logic ack_on;
        logic begin_req;
        logic halt_req;
        logic coll;
        logic on;
        logic rsv;
        logic irq_on;
    } cmd_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } lines_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_WAIT_FREE,
        S_START,
        S_BYTE,
        S_HOLD,
        S_STOP
    } seq_t;

endpackage

// >>> two_wire_master_sequencer.sv
`timescale 1ns/10ps
// Contract
// - Status codes assume prescaler bits zero; software masks them.
// - Master mode starts only with START; address direction bit picks send or receive.
// - Flag clear with begin request and enable set starts once bus is free.
// - After START the flag rises with code 08.
// - After address-plus-read the code is 38, 40 or 48.
// - In code 10 either direction may be loaded; write selects send mode.
// - In code 40 the next byte is answered by ack_on.
// - In code 48 only repeated START, STOP, or STOP then START follow.
// - In code 50 another byte is received, answered by ack_on.
// - In code 58 repeated START, STOP, or STOP then START follow.
// - Received byte sits in the shift register whenever the flag rises with code 50 or 58.
// - In codes 28/30 with no requests another byte is sent.
// - Clear with begin 1 and halt 0 gives repeated START.
// - Clear with halt 1 and begin 0 gives STOP, halt bit self-clears.
// - Clear with both set gives STOP then START, halt bit self-clears.
// - In code 38 with no requests the bus is released, block goes idle.
// - In code 38 with begin set, START follows once the bus is free.
// - Code 38 also covers loss during address-plus-read or a NACK bit.
// - After repeated START ownership stays; any slave or direction may follow.
// - Shift register write with flag low is dropped and sets collision.
`include "tw_defs.svh"

module two_wire_master_sequencer
    import tw_pkg::*;
#(
    parameter int QTR_CYC = `TW_QTR_CYC
) (
    // System
    input wire logic clk,
    input wire logic srst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Two-wire pins, open drain
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);

    logic acc;
    logic ack_ff;
    logic wr;
    logic [3:0] wadr;
    logic cmd_wr;
    logic stat_wr;
    logic data_wr;
    logic [31:0] dat_ff;

    cmd_t cmd_ff;
    logic flag_ff;
    logic coll_ff;
    logic [1:0] pre_ff;
    logic [7:0] shift_ff;
    logic [7:0] code_ff;
    logic go_ff;

    lines_t s1_ff;
    lines_t s2_ff;
    lines_t s3_ff;
    lines_t line_ff;
    lines_t prev_ff;
    logic busy_ff;

    logic [15:0] div_ff;
    logic tick;
    logic adv;

    seq_t state_ff;
    logic [1:0] ph_ff;
    logic [3:0] bit_ff;
    logic own_ff;
    logic rd_ff;
    logic addr_ff;
    logic rx_ff;
    logic ackbit_ff;
    logic got_ack_ff;
    logic scl_low_ff;
    logic sda_low_ff;
    logic set_ff;
    logic halt_clr_ff;
    logic samp_ff;
    logic samp_bit_ff;
    logic lost;

    // Bus slave: every access is answered one cycle after it is seen.
    assign acc = wb_cyc_i & wb_stb_i;
    assign wadr = {wb_adr_i[3:2], 2'b00};
    assign wr = acc & ack_ff & wb_we_i & wb_sel_i[0];
    assign cmd_wr = wr & (wadr == `TW_CMD_ADR);
    assign stat_wr = wr & (wadr == `TW_STAT_ADR);
    assign data_wr = wr & (wadr == `TW_DATA_ADR);
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= acc & ~ack_ff;
        end
    end

    // Unmapped addresses answer normally with zero data.
    always_ff @(posedge clk) begin
        if (srst) begin
            dat_ff <= 32'h00000000;
        end else if (acc & ~ack_ff) begin
            unique case (wadr)
                `TW_CMD_ADR: dat_ff <= {24'h000000, flag_ff, cmd_ff.ack_on, cmd_ff.begin_req,
                                        cmd_ff.halt_req, coll_ff, cmd_ff.on, 1'b0, cmd_ff.irq_on};
                `TW_STAT_ADR: dat_ff <= {24'h000000, code_ff[7:3], 1'b0, pre_ff};
                `TW_DATA_ADR: dat_ff <= {24'h000000, shift_ff};
                default: dat_ff <= 32'h00000000;
            endcase
        end
    end

    // Software fields of the command register; a write beats the self-clear.
    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_ff <= `TW_CMD_RST;
        end else if (cmd_wr) begin
            cmd_ff <= wb_dat_i[7:0];
            cmd_ff.flag <= 1'b0;
            cmd_ff.coll <= 1'b0;
            cmd_ff.rsv <= 1'b0;
        end else if (halt_clr_ff) begin
            cmd_ff.halt_req <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            go_ff <= 1'b0;
        end else begin
            go_ff <= cmd_wr & wb_dat_i[`TW_FLAG_BIT];
        end
    end

    // The hardware set wins over a software clear in the same cycle.
    always_ff @(posedge clk) begin
        if (srst) begin
            flag_ff <= 1'b0;
        end else if (set_ff) begin
            flag_ff <= 1'b1;
        end else if (cmd_wr & wb_dat_i[`TW_FLAG_BIT]) begin
            flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            coll_ff <= 1'b0;
        end else if (data_wr) begin
            coll_ff <= ~flag_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pre_ff <= `TW_PRE_RST;
        end else if (stat_wr) begin
            pre_ff <= wb_dat_i[`TW_PRE_MSB:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            shift_ff <= `TW_DATA_RST;
        end else if (data_wr & flag_ff) begin
            shift_ff <= wb_dat_i[7:0];
        end else if (samp_ff) begin
            shift_ff <= {shift_ff[6:0], samp_bit_ff};
        end
    end

    // Pin synchroniser: a line changes only once stages two and three agree.
    always_ff @(posedge clk) begin
        if (srst) begin
            s1_ff <= '1;
            s2_ff <= '1;
            s3_ff <= '1;
            line_ff <= '1;
            prev_ff <= '1;
        end else begin
            s1_ff <= '{scl: scl_i, sda: sda_i};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff.scl == s3_ff.scl) begin
                line_ff.scl <= s3_ff.scl;
            end
            if (s2_ff.sda == s3_ff.sda) begin
                line_ff.sda <= s3_ff.sda;
            end
            prev_ff <= line_ff;
        end
    end

    // Bus busy between any START and the next STOP, ours or another master's.
    always_ff @(posedge clk) begin
        if (srst) begin
            busy_ff <= 1'b0;
        end else if (line_ff.scl & prev_ff.scl & prev_ff.sda & ~line_ff.sda) begin
            busy_ff <= 1'b1;
        end else if (line_ff.scl & prev_ff.scl & ~prev_ff.sda & line_ff.sda) begin
            busy_ff <= 1'b0;
        end
    end

    // Quarter bit period enable.
    assign tick = (div_ff == 16'(QTR_CYC - 1));

    always_ff @(posedge clk) begin
        if (srst) begin
            div_ff <= 16'h0000;
        end else if (tick) begin
            div_ff <= 16'h0000;
        end else begin
            div_ff <= div_ff + 16'h0001;
        end
    end

    // Phase 1 stalls until the clock line is seen high, so slow slaves may stretch it.
    assign adv = tick & ((ph_ff != 2'h1) | line_ff.scl);

    // Another master pulled data low while this one released it.
    assign lost = ~sda_low_ff & ~line_ff.sda & (rx_ff ? (bit_ff == 4'h8) : (bit_ff != 4'h8));

    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = scl_low_ff;
    assign sda_oe = sda_low_ff;

    function automatic logic drv_low(input logic [3:0] b);
        if (b == 4'h8) begin
            return rx_ff & ackbit_ff;
        end
        return ~rx_ff & ~shift_ff[3'(4'h7 - b)];
    endfunction

    // Sequencer.
    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= S_IDLE;
            ph_ff <= 2'h0;
            bit_ff <= 4'h0;
            own_ff <= 1'b0;
            rd_ff <= 1'b0;
            addr_ff <= 1'b0;
            rx_ff <= 1'b0;
            ackbit_ff <= 1'b0;
            got_ack_ff <= 1'b0;
            scl_low_ff <= 1'b0;
            sda_low_ff <= 1'b0;
            code_ff <= `TW_SC_IDLE;
            set_ff <= 1'b0;
            halt_clr_ff <= 1'b0;
            samp_ff <= 1'b0;
            samp_bit_ff <= 1'b0;
        end else begin
            set_ff <= 1'b0;
            halt_clr_ff <= 1'b0;
            samp_ff <= 1'b0;
            if (~cmd_ff.on) begin
                state_ff <= S_IDLE;
                own_ff <= 1'b0;
                scl_low_ff <= 1'b0;
                sda_low_ff <= 1'b0;
            end else begin
                unique case (state_ff)
                    S_IDLE: begin
                        if (go_ff & cmd_ff.begin_req) begin
                            state_ff <= S_WAIT_FREE;
                        end
                    end
                    S_WAIT_FREE: begin
                        if (tick & ~busy_ff) begin
                            state_ff <= S_START;
                            ph_ff <= 2'h0;
                        end
                    end
                    S_START: begin
                        if (adv) begin
                            ph_ff <= ph_ff + 2'h1;
                            unique case (ph_ff)
                                2'h0: scl_low_ff <= 1'b0;
                                2'h1: sda_low_ff <= 1'b1;
                                2'h2: scl_low_ff <= 1'b1;
                                2'h3: begin
                                    code_ff <= own_ff ? `TW_SC_RSTART : `TW_SC_START;
                                    own_ff <= 1'b1;
                                    addr_ff <= 1'b1;
                                    set_ff <= 1'b1;
                                    state_ff <= S_HOLD;
                                end
                            endcase
                        end
                    end
                    S_BYTE: begin
                        if (adv) begin
                            ph_ff <= ph_ff + 2'h1;
                            unique case (ph_ff)
                                2'h0: scl_low_ff <= 1'b0;
                                2'h1: begin
                                    if (lost) begin
                                        // Let go of both lines at once; the winner owns the clock now.
                                        scl_low_ff <= 1'b0;
                                        sda_low_ff <= 1'b0;
                                        own_ff <= 1'b0;
                                        code_ff <= `TW_SC_ARB;
                                        set_ff <= 1'b1;
                                        state_ff <= S_HOLD;
                                    end else if (bit_ff == 4'h8) begin
                                        got_ack_ff <= ~line_ff.sda;
                                    end else if (rx_ff) begin
                                        samp_ff <= 1'b1;
                                        samp_bit_ff <= line_ff.sda;
                                    end
                                end
                                2'h2: scl_low_ff <= 1'b1;
                                2'h3: begin
                                    if (bit_ff == 4'h8) begin
                                        sda_low_ff <= 1'b0;
                                        addr_ff <= 1'b0;
                                        set_ff <= 1'b1;
                                        state_ff <= S_HOLD;
                                        if (addr_ff & rd_ff) begin
                                            code_ff <= got_ack_ff ? `TW_SC_AR_ACK : `TW_SC_AR_NACK;
                                        end else if (addr_ff) begin
                                            code_ff <= got_ack_ff ? `TW_SC_AW_ACK : `TW_SC_AW_NACK;
                                        end else if (rx_ff) begin
                                            code_ff <= ackbit_ff ? `TW_SC_DR_ACK : `TW_SC_DR_NACK;
                                        end else begin
                                            code_ff <= got_ack_ff ? `TW_SC_DW_ACK : `TW_SC_DW_NACK;
                                        end
                                    end else begin
                                        bit_ff <= bit_ff + 4'h1;
                                        sda_low_ff <= drv_low(bit_ff + 4'h1);
                                    end
                                end
                            endcase
                        end
                    end
                    S_HOLD: begin
                        if (go_ff) begin
                            ph_ff <= 2'h0;
                            if (~own_ff) begin
                                code_ff <= `TW_SC_IDLE;
                                state_ff <= cmd_ff.begin_req ? S_WAIT_FREE : S_IDLE;
                            end else if (cmd_ff.halt_req) begin
                                sda_low_ff <= 1'b1;
                                state_ff <= S_STOP;
                            end else if (cmd_ff.begin_req) begin
                                sda_low_ff <= 1'b0;
                                state_ff <= S_START;
                            end else if (code_ff == `TW_SC_AR_NACK || code_ff == `TW_SC_DR_NACK) begin
                                // No data step follows a refused read; the flag comes straight back.
                                set_ff <= 1'b1;
                            end else begin
                                bit_ff <= 4'h0;
                                ackbit_ff <= cmd_ff.ack_on;
                                if (addr_ff) begin
                                    rd_ff <= shift_ff[0];
                                    rx_ff <= 1'b0;
                                    sda_low_ff <= ~shift_ff[7];
                                end else begin
                                    rx_ff <= rd_ff;
                                    sda_low_ff <= ~rd_ff & ~shift_ff[7];
                                end
                                state_ff <= S_BYTE;
                            end
                        end
                    end
                    S_STOP: begin
                        if (adv) begin
                            ph_ff <= ph_ff + 2'h1;
                            unique case (ph_ff)
                                2'h0: scl_low_ff <= 1'b0;
                                2'h1: sda_low_ff <= 1'b0;
                                2'h2: begin
                                    own_ff <= 1'b0;
                                    halt_clr_ff <= 1'b1;
                                    code_ff <= `TW_SC_IDLE;
                                    state_ff <= cmd_ff.begin_req ? S_WAIT_FREE : S_IDLE;
                                end
                                2'h3: state_ff <= S_IDLE;
                            endcase
                        end
                    end
                endcase
            end
        end
    end

endmodule

// >>> tw_seq_monitor.sv
`timescale 1ns/10ps
module tw_seq_monitor (
    // System
    input wire logic clk,
    input wire logic srst,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Two-wire pins
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper data set");
    a_hole_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h3 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_status_mask: assert property (wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h1 |-> !wb_dat_o[2])
        else $error("status bit two set");
    a_pins_low: assert property (!scl_o && !sda_o) else $error("pin data not low");
    a_reset_free: assert property ($fell(srst) |-> !scl_oe && !sda_oe && !wb_ack_o) else $error("reset not idle");
    // A start pulls data only while the clock wire is high.
    a_start_shape: assert property ($rose(sda_oe) && !scl_oe |-> scl_i)
        else $error("data pulled with clock low");
    a_scl_held: assert property (wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h0 && wb_dat_o[7] && scl_oe |=> scl_oe)
        else $error("clock released while suspended");
    c_arb: cover property (wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h1 && wb_dat_o[7:0] == 8'h38);
    c_rx_ack: cover property (wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h1 && wb_dat_o[7:0] == 8'h50);
    c_rx_nack: cover property (wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h1 && wb_dat_o[7:0] == 8'h58);
endmodule

bind two_wire_master_sequencer tw_seq_monitor tw_seq_monitor_i (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

// >>> tw_slave_model.sv
`timescale 1ns/10ps
module tw_slave_model #(
    parameter logic [6:0] ADDR = 7'h50
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl,
    input wire logic sda,
    input wire logic arb_en,
    output logic sda_pull
);
    logic scl_ff, sda_ff, act_ff, adr_ff, rd_ff, send_ff, drv_ff;
    logic [3:0] bit_ff;
    logic [7:0] sh_ff, tx_ff;
    logic [5:0] arb_ff;
    // A rival master holds data low for a while after it wins a bit.
    assign sda_pull = drv_ff | (arb_ff != 6'h00);
    always_ff @(posedge clk) begin
        scl_ff <= scl;
        sda_ff <= sda;
        if (srst) begin
            act_ff <= 1'b0;
            drv_ff <= 1'b0;
            arb_ff <= 6'h00;
            tx_ff <= 8'h5A;
        end else if (scl && scl_ff && sda_ff && !sda && arb_ff == 6'h00) begin
            act_ff <= 1'b1;
            adr_ff <= 1'b1;
            send_ff <= 1'b0;
            drv_ff <= 1'b0;
            bit_ff <= 4'h0;
        end else if (scl && scl_ff && !sda_ff && sda) begin
            act_ff <= 1'b0;
            drv_ff <= 1'b0;
        end else if (act_ff) begin
            if (arb_ff != 6'h00) arb_ff <= arb_ff - 6'h01;
            if (scl && !scl_ff) begin
                sh_ff <= {sh_ff[6:0], sda};
                bit_ff <= bit_ff + 4'h1;
                if (arb_en && adr_ff && bit_ff == 4'h0) arb_ff <= 6'h28;
                if (bit_ff == 4'h8 && !adr_ff && rd_ff && sda) send_ff <= 1'b0;
            end
            if (!scl && scl_ff) begin
                if (bit_ff == 4'h8 && adr_ff) begin
                    rd_ff <= sh_ff[0];
                    send_ff <= sh_ff[0] && sh_ff[7:1] == ADDR;
                    drv_ff <= sh_ff[7:1] == ADDR;
                end else if (bit_ff == 4'h8) begin
                    drv_ff <= !rd_ff;
                    if (rd_ff) tx_ff <= tx_ff + 8'h01;
                end else if (bit_ff == 4'h9) begin
                    bit_ff <= 4'h0;
                    adr_ff <= 1'b0;
                    drv_ff <= send_ff && !tx_ff[7];
                end else if (send_ff && bit_ff != 4'h0) begin
                    drv_ff <= !tx_ff[3'h7 - bit_ff[2:0]];
                end
            end
        end
    end
endmodule

// >>> test_two_wire_master_sequencer.sv
`timescale 1ns/10ps
`include "tw_defs.svh"
module test_two_wire_master_sequencer;
    `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
        $display("[FAIL] %0t got %h expected %h", $time, (a), (b)); end end
    typedef struct packed {logic [3:0] a; logic w; logic [7:0] d; logic [7:0] e;} row_t;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, arb_en = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, scl_o, scl_oe, sda_o, sda_oe, pull;
    logic [7:0] q;
    int err_total = 0;
    int num_checks = 0;
    int n;
    wire scl_w = ~scl_oe;
    wire sda_w = ~(sda_oe | pull);
    row_t rows [0:9] = '{{4'h0, 1'b0, 8'h00, 8'h00}, {4'h4, 1'b0, 8'h00, 8'hF8}, {4'h8, 1'b0, 8'h00, 8'hFF},
        {4'hC, 1'b0, 8'h00, 8'h00}, {4'h4, 1'b1, 8'h03, 8'h00}, {4'h4, 1'b0, 8'h00, 8'hFB},
        {4'h4, 1'b1, 8'h00, 8'h00}, {4'hC, 1'b1, 8'h5A, 8'h00}, {4'hC, 1'b0, 8'h00, 8'h00},
        {4'h0, 1'b0, 8'h00, 8'h00}};
    always #10 clk = ~clk;
    two_wire_master_sequencer #(.QTR_CYC(2)) two_wire_master_sequencer_i (.clk(clk), .srst(srst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
    tw_slave_model tw_slave_model_i (.clk(clk), .srst(srst), .scl(scl_w), .sda(sda_w), .arb_en(arb_en),
        .sda_pull(pull));
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= a;
        wdat <= {24'h000000, d};
        k = 0;
        // The request stands until the edge that sees ack; data is taken and the request dropped there.
        do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 20);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        if (k >= 20) begin err_total++; close_out(); end
    endtask
    task automatic poll(input logic [7:0] m, input logic [7:0] v);
        int k;
        k = 0;
        do begin bus(4'h0, 1'b0, 8'h00); k++; end while ((q & m) !== v && k < 200);
        if (k >= 200) begin err_total++; close_out(); end
    endtask
    // Resume with a command and expect the masked code at the next suspension.
    task automatic step(input logic [7:0] c, input logic [7:0] code);
        bus(4'h0, 1'b1, c);
        poll(8'h80, 8'h80);
        bus(4'h4, 1'b0, 8'h00);
        `CHK(q & 8'hF8, code)
    endtask
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            bus(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w) `CHK(q, rows[i].e)
        end
        bus(4'h8, 1'b1, 8'h11);
        bus(4'h0, 1'b0, 8'h00);
        `CHK(q[3], 1'b1)
        `CHK(scl_oe | sda_oe, 1'b0)
        step(8'hA4, `TW_SC_START);
        bus(4'h8, 1'b1, 8'hA1);
        bus(4'h0, 1'b0, 8'h00);
        `CHK(q[3], 1'b0)
        step(8'hC4, `TW_SC_AR_ACK);
        step(8'hC4, `TW_SC_DR_ACK);
        bus(4'h8, 1'b0, 8'h00);
        `CHK(q, 8'h5A)
        step(8'h84, `TW_SC_DR_NACK);
        bus(4'h8, 1'b0, 8'h00);
        `CHK(q, 8'h5B)
        step(8'hA4, `TW_SC_RSTART);
        bus(4'h8, 1'b1, 8'hA0);
        step(8'h84, `TW_SC_AW_ACK);
        bus(4'h8, 1'b1, 8'h77);
        step(8'h84, `TW_SC_DW_ACK);
        bus(4'h0, 1'b1, 8'h94);
        poll(8'h10, 8'h00);
        `CHK(q[7], 1'b0)
        for (n = 0; n < 100 && (scl_oe | sda_oe) !== 1'b0; n++) @(negedge clk);
        `CHK(scl_oe | sda_oe, 1'b0)
        step(8'hA4, `TW_SC_START);
        bus(4'h8, 1'b1, 8'hB3);
        step(8'h84, `TW_SC_AR_NACK);
        step(8'h84, `TW_SC_AR_NACK);
        `CHK({scl_oe, sda_oe}, 2'b10)
        step(8'hB4, `TW_SC_START);
        bus(4'h0, 1'b0, 8'h00);
        `CHK(q[4], 1'b0)
        @(posedge clk) arb_en <= 1'b1;
        bus(4'h8, 1'b1, 8'hA1);
        step(8'h84, `TW_SC_ARB);
        step(8'hA4, `TW_SC_START);
        bus(4'h8, 1'b1, 8'hA1);
        step(8'h84, `TW_SC_ARB);
        bus(4'h0, 1'b1, 8'h84);
        bus(4'h4, 1'b0, 8'h00);
        `CHK(q, 8'hF8)
        `CHK(scl_oe | sda_oe, 1'b0)
        @(posedge clk) srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        bus(4'h8, 1'b0, 8'h00);
        `CHK(q, 8'hFF)
        close_out();
    end
endmodule
